/* verilog/flfe_pkg.sv */
// Purpose: Shared constants and types of the forward lookup front end
// Assumes: One 25 MHz clock, synchronous active-low reset
// Notes:   Byte offsets are those of the 8-bit management port
`default_nettype none

package flfe_pkg;
    localparam int PORTS = 16;
    typedef logic [3:0] flfe_port_t;
    typedef logic [PORTS-1:0] flfe_vec_t;
    typedef logic [35:0] flfe_word_t;

    // Management port register offsets
    localparam logic [7:0] ADDR_FWD_BLOCK_LO = 8'hf4;
    localparam logic [7:0] ADDR_FWD_BLOCK_HI = 8'hf5;
    localparam logic [7:0] ADDR_RX_BLOCK_LO = 8'hf6;
    localparam logic [7:0] ADDR_RX_BLOCK_HI = 8'hf7;
    localparam logic [7:0] ADDR_CPU_STEER = 8'hf8;

    // Reset values
    localparam flfe_vec_t RST_FWD_BLOCK = 16'h0000;
    localparam flfe_vec_t RST_RX_BLOCK = 16'h0000;
    localparam logic [7:0] RST_CPU_STEER = 8'h0f;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    // Steering register fields
    localparam int STEER_CPU_HI = 7;
    localparam int STEER_CPU_LO = 4;
    localparam int STEER_DST_HI = 3;
    localparam int STEER_DST_LO = 0;
    localparam flfe_port_t STEER_OFF = 4'hf;

    // Buffer-memory word fields
    localparam int FLAG_HI = 35;
    localparam int FLAG_LO = 34;
    localparam int LIST_BIT = 35;
    localparam int CHAN_HI = 27;
    localparam int CHAN_LO = 24;
    localparam int DA_HI = 31;
    localparam int DA_LO = 0;
    localparam logic [1:0] SOF_FLAGS = 2'b01;

    // Answer deadline
    localparam int CLK_PERIOD_NS = 40;
    localparam int DEADLINE_NS = 440;
    localparam int DEADLINE_CYC = DEADLINE_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } flfe_state_t;
endpackage

`default_nettype wire

/* verilog/flfe_dec_if.sv */
// Purpose: Carries the forwarding decision inputs and results
// Assumes: Driven and read on the same clock
// Notes:   Purely combinational path
`default_nettype none

interface flfe_dec_if;
    import flfe_pkg::*;
    flfe_vec_t lookup_vec;
    flfe_vec_t vlan_vec;
    flfe_vec_t fwd_mask;
    flfe_vec_t rx_mask;
    flfe_port_t src_port;
    flfe_port_t steer_cpu;
    flfe_port_t steer_dst;
    logic exempt;
    logic steered;
    logic rx_blocked;
    logic discard;
    logic single;
    flfe_port_t port;
    flfe_vec_t vec;

    modport top (
        output lookup_vec, vlan_vec, fwd_mask, rx_mask, src_port, steer_cpu, steer_dst, exempt,
        input steered, rx_blocked, discard, single, port, vec
    );
    modport dec (
        input lookup_vec, vlan_vec, fwd_mask, rx_mask, src_port, steer_cpu, steer_dst, exempt,
        output steered, rx_blocked, discard, single, port, vec
    );
endinterface

`default_nettype wire

/* verilog/flfe_reduce.sv */
// Purpose: Chooses the forwarding code for one looked-up frame
// Assumes: Inputs stable in the cycle the result is taken
// Notes:   Receive blocking ranks above steering
`default_nettype none

module flfe_reduce (
    flfe_dec_if.dec d
);
    import flfe_pkg::*;

    function automatic flfe_vec_t port_bit(input flfe_port_t p);
        flfe_vec_t v;
        v = '0;
        v[p] = 1'b1;
        return v;
    endfunction

    function automatic logic [4:0] count_ones(input flfe_vec_t v);
        logic [4:0] c;
        c = '0;
        for (int i = 0; i < PORTS; i++) begin
            c = c + 5'(v[i]);
        end
        return c;
    endfunction

    function automatic flfe_port_t first_port(input flfe_vec_t v);
        flfe_port_t p;
        p = '0;
        for (int i = PORTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                p = 4'(i);
            end
        end
        return p;
    endfunction

    flfe_vec_t masked;
    logic [4:0] cnt;

    always_comb begin
        // Steering needs a valid CPU port, an armed destination and a CPU source
        d.steered = (d.steer_dst != STEER_OFF) && (d.steer_cpu != STEER_OFF) &&
                    (d.src_port == d.steer_cpu);
        d.rx_blocked = d.rx_mask[d.src_port] && !d.exempt;
        // VLAN mask, drop source port and forward-blocked ports
        masked = d.lookup_vec & d.vlan_vec & ~port_bit(d.src_port) & ~d.fwd_mask;
        cnt = count_ones(masked);
        d.discard = 1'b0;
        d.single = 1'b0;
        d.port = '0;
        d.vec = '0;
        if (d.rx_blocked) begin
            d.discard = 1'b1;
        end else if (d.steered) begin
            d.single = 1'b1;
            d.port = d.steer_dst;
            d.vec = port_bit(d.steer_dst);
        end else if (cnt == 5'h00) begin
            d.discard = 1'b1;
        end else begin
            d.single = (cnt == 5'h01);
            d.port = first_port(masked);
            d.vec = masked;
        end
    end
endmodule

`default_nettype wire

/* verilog/flfe_top.sv */
// Purpose: Forward lookup front end watching the buffer-memory bus
// Assumes: Bus and management port are synchronous to i_clk
// Notes:   Table storage lives outside; results come back on i_lookup_*
//
// Function
// - Discard frames whose source port is set in the receive block mask.
// - Block-exempt flag on the destination entry lets a receive-blocked frame through.
// - CPU port comes from steering bits 7-4; value 0xf is ignored.
// - Steering destination 0xf keeps steering off; lookup result routes frames.
// - Armed steering sends CPU-port frames to the coded port, ignoring lookup.
// - After one steered frame the device writes 0xf to the destination field; a host steering write in that same cycle wins instead.
// - Prefer single-port codes over multi-port codes whenever possible.
// - Reduce sets by VLAN mask, source removal, forward-block removal; one left is single.
// - Frame start is found from the flag bits of the first flag word.
// - On the cycle of the flag word, capture the first 32 DA bits from that same word.
// - The forwarding code is presented within 440 ns of the DA capture.
// - Only buffers with broadcast-list flag 0 are frame data and start lookups.
// - Source port comes from the channel code written with the first buffer.
// - Start of frame is flags 35-34 equal to 01 in data cycle 1.
// - Forward-blocked ports get no frames except a steered frame.
// - Receive-blocked frames do not advance statistics counters.
`default_nettype none

module flfe_top (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_dd_valid,
    input wire flfe_pkg::flfe_word_t i_dd,
    input wire logic [7:0] i_host_addr,
    input wire logic [7:0] i_host_wdata,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    output logic [7:0] o_host_rdata,
    output logic o_lookup_req,
    output logic [31:0] o_lookup_da,
    output flfe_pkg::flfe_port_t o_src_port,
    input wire logic i_lookup_valid,
    input wire flfe_pkg::flfe_vec_t i_lookup_vec,
    input wire logic i_lookup_exempt,
    input wire flfe_pkg::flfe_vec_t i_src_vlan_vec,
    output logic o_match_valid,
    output logic o_match_discard,
    output logic o_match_single,
    output flfe_pkg::flfe_port_t o_match_port,
    output flfe_pkg::flfe_vec_t o_match_vec,
    output logic o_stat_count_en
);
    import flfe_pkg::*;

    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(DEADLINE_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    flfe_state_t state_ff, nxt_state;
    logic [TMR_W-1:0] tmr_ff, nxt_tmr;
    logic prev_seen_ff, nxt_prev_seen;
    logic prev_list_ff, nxt_prev_list;
    flfe_port_t prev_chan_ff, nxt_prev_chan;
    flfe_vec_t fwd_mask_ff, nxt_fwd_mask;
    flfe_vec_t rx_mask_ff, nxt_rx_mask;
    logic [7:0] steer_ff, nxt_steer;
    logic [7:0] rdata_ff, nxt_rdata;
    logic req_ff, nxt_req;
    logic [31:0] da_ff, nxt_da;
    flfe_port_t src_ff, nxt_src;
    logic mvalid_ff, nxt_mvalid;
    logic mdiscard_ff, nxt_mdiscard;
    logic msingle_ff, nxt_msingle;
    flfe_port_t mport_ff, nxt_mport;
    flfe_vec_t mvec_ff, nxt_mvec;
    logic count_ff, nxt_count;
    logic sof_hit;
    logic steer_wr;

    flfe_dec_if dec ();

    flfe_reduce u_reduce (
        .d(dec.dec)
    );

    assign dec.lookup_vec = i_lookup_vec;
    assign dec.vlan_vec = i_src_vlan_vec;
    assign dec.fwd_mask = fwd_mask_ff;
    assign dec.rx_mask = rx_mask_ff;
    assign dec.src_port = src_ff;
    assign dec.steer_cpu = steer_ff[STEER_CPU_HI:STEER_CPU_LO];
    assign dec.steer_dst = steer_ff[STEER_DST_HI:STEER_DST_LO];
    assign dec.exempt = i_lookup_exempt;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        // Start of frame: flag word 01 after a data (non broadcast-list) first word
        sof_hit = i_dd_valid && (i_dd[FLAG_HI:FLAG_LO] == SOF_FLAGS) &&
                  prev_seen_ff && !prev_list_ff;
        steer_wr = i_host_wr && (i_host_addr == ADDR_CPU_STEER);
        nxt_state = state_ff;
        nxt_tmr = tmr_ff;
        nxt_prev_seen = prev_seen_ff;
        nxt_prev_list = prev_list_ff;
        nxt_prev_chan = prev_chan_ff;
        nxt_fwd_mask = fwd_mask_ff;
        nxt_rx_mask = rx_mask_ff;
        nxt_steer = steer_ff;
        nxt_rdata = rdata_ff;
        nxt_req = 1'b0;
        nxt_da = da_ff;
        nxt_src = src_ff;
        nxt_mvalid = 1'b0;
        nxt_mdiscard = mdiscard_ff;
        nxt_msingle = msingle_ff;
        nxt_mport = mport_ff;
        nxt_mvec = mvec_ff;
        nxt_count = 1'b0;

        if (i_dd_valid) begin
            nxt_prev_seen = 1'b1;
            nxt_prev_list = i_dd[LIST_BIT];
            nxt_prev_chan = i_dd[CHAN_HI:CHAN_LO];
        end

        case (state_ff)
            ST_IDLE: begin
                if (sof_hit) begin
                    nxt_da = i_dd[DA_HI:DA_LO];
                    nxt_src = prev_chan_ff;
                    nxt_req = 1'b1;
                    nxt_tmr = '0;
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                nxt_tmr = tmr_ff + 1'b1;
                if (i_lookup_valid) begin
                    nxt_mvalid = 1'b1;
                    nxt_mdiscard = dec.discard;
                    nxt_msingle = dec.single;
                    nxt_mport = dec.port;
                    nxt_mvec = dec.vec;
                    nxt_count = !dec.rx_blocked;
                    if (dec.steered && !dec.rx_blocked) begin
                        nxt_steer[STEER_DST_HI:STEER_DST_LO] = STEER_OFF;
                    end
                    nxt_state = ST_IDLE;
                end else if (tmr_ff == TMR_LAST) begin
                    nxt_mvalid = 1'b1;
                    nxt_mdiscard = 1'b1;
                    nxt_msingle = 1'b0;
                    nxt_mport = '0;
                    nxt_mvec = '0;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase

        // Management writes; a write to the steering register wins over self-disarm
        if (i_host_wr) begin
            if (i_host_addr == ADDR_FWD_BLOCK_LO) begin
                nxt_fwd_mask[7:0] = i_host_wdata;
            end else if (i_host_addr == ADDR_FWD_BLOCK_HI) begin
                nxt_fwd_mask[15:8] = i_host_wdata;
            end else if (i_host_addr == ADDR_RX_BLOCK_LO) begin
                nxt_rx_mask[7:0] = i_host_wdata;
            end else if (i_host_addr == ADDR_RX_BLOCK_HI) begin
                nxt_rx_mask[15:8] = i_host_wdata;
            end else if (steer_wr) begin
                nxt_steer = i_host_wdata;
            end
        end

        // Management reads
        if (i_host_rd) begin
            if (i_host_addr == ADDR_FWD_BLOCK_LO) begin
                nxt_rdata = fwd_mask_ff[7:0];
            end else if (i_host_addr == ADDR_FWD_BLOCK_HI) begin
                nxt_rdata = fwd_mask_ff[15:8];
            end else if (i_host_addr == ADDR_RX_BLOCK_LO) begin
                nxt_rdata = rx_mask_ff[7:0];
            end else if (i_host_addr == ADDR_RX_BLOCK_HI) begin
                nxt_rdata = rx_mask_ff[15:8];
            end else if (i_host_addr == ADDR_CPU_STEER) begin
                nxt_rdata = steer_ff;
            end else begin
                nxt_rdata = RDATA_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_ff <= ST_IDLE;
            tmr_ff <= '0;
            prev_seen_ff <= 1'b0;
            prev_list_ff <= 1'b0;
            prev_chan_ff <= '0;
            fwd_mask_ff <= RST_FWD_BLOCK;
            rx_mask_ff <= RST_RX_BLOCK;
            steer_ff <= RST_CPU_STEER;
            rdata_ff <= RDATA_NONE;
            req_ff <= 1'b0;
            da_ff <= '0;
            src_ff <= '0;
            mvalid_ff <= 1'b0;
            mdiscard_ff <= 1'b0;
            msingle_ff <= 1'b0;
            mport_ff <= '0;
            mvec_ff <= '0;
            count_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tmr_ff <= nxt_tmr;
            prev_seen_ff <= nxt_prev_seen;
            prev_list_ff <= nxt_prev_list;
            prev_chan_ff <= nxt_prev_chan;
            fwd_mask_ff <= nxt_fwd_mask;
            rx_mask_ff <= nxt_rx_mask;
            steer_ff <= nxt_steer;
            rdata_ff <= nxt_rdata;
            req_ff <= nxt_req;
            da_ff <= nxt_da;
            src_ff <= nxt_src;
            mvalid_ff <= nxt_mvalid;
            mdiscard_ff <= nxt_mdiscard;
            msingle_ff <= nxt_msingle;
            mport_ff <= nxt_mport;
            mvec_ff <= nxt_mvec;
            count_ff <= nxt_count;
        end
    end

    assign o_host_rdata = rdata_ff;
    assign o_lookup_req = req_ff;
    assign o_lookup_da = da_ff;
    assign o_src_port = src_ff;
    assign o_match_valid = mvalid_ff;
    assign o_match_discard = mdiscard_ff;
    assign o_match_single = msingle_ff;
    assign o_match_port = mport_ff;
    assign o_match_vec = mvec_ff;
    assign o_stat_count_en = count_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    logic take;
    assign take = (state_ff == ST_WAIT) && i_lookup_valid;

    AST_DEADLINE: assert property (o_lookup_req |-> ##[1:11] o_match_valid)
        else $error("forwarding code late");
    AST_CAPTURE: assert property ((state_ff == ST_IDLE) && sof_hit |=>
        o_lookup_req && (o_lookup_da == $past(i_dd[DA_HI:DA_LO])))
        else $error("DA not captured after start of frame");
    AST_LIST_BUF: assert property ((state_ff == ST_IDLE) && i_dd_valid && prev_list_ff |=> !o_lookup_req)
        else $error("broadcast-list buffer started a lookup");
    AST_SRC: assert property ($rose(o_lookup_req) |-> o_src_port == $past(prev_chan_ff))
        else $error("source port not from channel code");
    AST_RECEIVE_PORT_BLOCK_MASK: assert property (take && rx_mask_ff[src_ff] && !i_lookup_exempt |=>
        o_match_valid && o_match_discard && !o_stat_count_en)
        else $error("receive-blocked frame not discarded");
    AST_EXEMPT: assert property (take && rx_mask_ff[src_ff] && i_lookup_exempt |=> o_stat_count_en)
        else $error("exempt frame was blocked");
    AST_CPUFIELD: assert property (take && (steer_ff[STEER_CPU_HI:STEER_CPU_LO] == STEER_OFF) |-> !dec.steered)
        else $error("reserved CPU port value steered a frame");
    AST_STEER_OFF: assert property (take && !dec.steered |=>
        (o_match_vec & ~$past(i_lookup_vec)) == '0)
        else $error("unsteered frame left its lookup set");
    AST_STEER_ROUTE: assert property (take && dec.steered && !dec.rx_blocked |=>
        o_match_single && (o_match_port == $past(steer_ff[STEER_DST_HI:STEER_DST_LO])))
        else $error("steered frame misrouted");
    AST_STEER_CLEAR: assert property (take && dec.steered && !dec.rx_blocked && !steer_wr |=>
        steer_ff[STEER_DST_HI:STEER_DST_LO] == STEER_OFF)
        else $error("steering not disarmed");
    AST_NONCPU: assert property (take && (src_ff != steer_ff[STEER_CPU_HI:STEER_CPU_LO]) |-> !dec.steered)
        else $error("non-CPU frame steered");
    AST_FWDBLOCK: assert property (take && !dec.steered |=>
        (o_match_vec & $past(fwd_mask_ff)) == '0)
        else $error("forward-blocked port in code");
    AST_SINGLE: assert property (o_match_valid && !o_match_discard |->
        o_match_single == ($countones(o_match_vec) == 1))
        else $error("single-port code not preferred");

    COV_STEER: cover property (take && dec.steered ##1 o_match_valid);
    COV_MULTI: cover property (o_match_valid && !o_match_single && !o_match_discard);
    COV_TIMEOUT: cover property ((state_ff == ST_WAIT) && (tmr_ff == TMR_LAST) && !i_lookup_valid);
    COV_RECEIVE_PORT_BLOCK_MASK: cover property (take && dec.rx_blocked);
endmodule

`default_nettype wire

/* verification/flfe_ctl_model.sv */
// Purpose: Switch controller stand-in that writes buffers and answers table lookups
// Assumes: Drives on the falling edge of the bench clock
// Notes:   Lines not carrying a value show inverted data, never a held value
`default_nettype none

module flfe_ctl_model (
    input wire logic i_clk,
    input wire logic i_lookup_req,
    input wire logic i_match_valid,
    input wire logic i_match_single,
    input wire logic i_match_discard,
    output logic o_dd_valid,
    output flfe_pkg::flfe_word_t o_dd,
    output logic o_lookup_valid,
    output flfe_pkg::flfe_vec_t o_lookup_vec,
    output logic o_lookup_exempt,
    output flfe_pkg::flfe_vec_t o_src_vlan_vec
);
    timeunit 1ns;
    timeprecision 1ps;
    import flfe_pkg::*;
    flfe_vec_t cfg_vec = '0;
    flfe_vec_t cfg_vlan = '0;
    logic cfg_exempt = 1'b0;
    int delay = 1;
    int cnt = 0;
    logic lv;
    int queued = 0;
    int lists = 0;

    initial begin
        o_dd_valid = 1'b0;
        o_dd = '0;
        o_lookup_valid = 1'b0;
        o_lookup_vec = '0;
        o_lookup_exempt = 1'b0;
        o_src_vlan_vec = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // First word with list flag and channel code, then the flag word
    task automatic send_frame(input logic lst, input flfe_port_t chan, input logic [1:0] flags,
                              input logic [31:0] da);
        @(negedge i_clk);
        o_dd_valid = 1'b1;
        o_dd = {lst, 7'h00, chan, 24'h5a5a5a};
        @(negedge i_clk);
        o_dd = {flags, 2'b00, da};
        @(negedge i_clk);
        o_dd_valid = 1'b0;
        o_dd = ~o_dd;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Table answer a set number of cycles after each request
    always @(negedge i_clk) begin
        lv = 1'b0;
        if (i_lookup_req === 1'b1) begin
            cnt = delay;
        end else if (cnt > 0) begin
            cnt = cnt - 1;
            lv = (cnt == 0);
        end
        o_lookup_valid = lv;
        o_lookup_vec = lv ? cfg_vec : ~cfg_vec;
        o_lookup_exempt = lv ? cfg_exempt : ~cfg_exempt;
        o_src_vlan_vec = lv ? cfg_vlan : ~cfg_vlan;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Single codes go to a port queue, multi codes build a broadcast list
    always @(posedge i_clk) begin
        if (i_match_valid === 1'b1 && i_match_discard === 1'b0) begin
            if (i_match_single === 1'b1) begin
                queued++;
            end else begin
                lists++;
            end
        end
    end
endmodule

`default_nettype wire

/* verification/flfe_tb_top.sv */
// Purpose: Self-checking bench of the forward lookup front end
// Assumes: Inputs change on the falling edge
// Notes:   Expected codes are worked out from the mask settings held here
`default_nettype none

module flfe_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import flfe_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] host_addr = 8'h00;
    logic [7:0] host_wdata = 8'h00;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [7:0] host_rdata;
    logic lookup_req, match_valid, match_discard, match_single, stat_count_en;
    logic dd_valid, lookup_valid, lookup_exempt;
    flfe_word_t dd;
    logic [31:0] lookup_da;
    flfe_port_t src_port, match_port;
    flfe_vec_t lookup_vec, src_vlan_vec, match_vec;
    flfe_vec_t fwd = '0;
    logic [22:0] code;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] ra [6] = '{ADDR_FWD_BLOCK_LO, ADDR_FWD_BLOCK_HI, ADDR_RX_BLOCK_LO, ADDR_RX_BLOCK_HI,
                           ADDR_CPU_STEER, 8'h10};
    logic [7:0] rv [6] = '{RST_FWD_BLOCK[7:0], RST_FWD_BLOCK[15:8], RST_RX_BLOCK[7:0], RST_RX_BLOCK[15:8],
                           RST_CPU_STEER, RDATA_NONE};
    logic [1:0] bad_flags [3] = '{2'b00, 2'b10, 2'b11};

    always #20 clk = ~clk;

    flfe_top i_flfe_top (.i_clk(clk), .i_reset_n(reset_n), .i_dd_valid(dd_valid), .i_dd(dd),
        .i_host_addr(host_addr), .i_host_wdata(host_wdata), .i_host_wr(host_wr), .i_host_rd(host_rd),
        .o_host_rdata(host_rdata), .o_lookup_req(lookup_req), .o_lookup_da(lookup_da), .o_src_port(src_port),
        .i_lookup_valid(lookup_valid), .i_lookup_vec(lookup_vec), .i_lookup_exempt(lookup_exempt),
        .i_src_vlan_vec(src_vlan_vec), .o_match_valid(match_valid), .o_match_discard(match_discard),
        .o_match_single(match_single), .o_match_port(match_port), .o_match_vec(match_vec),
        .o_stat_count_en(stat_count_en));

    flfe_ctl_model i_flfe_ctl_model (.i_clk(clk), .i_lookup_req(lookup_req), .i_match_valid(match_valid),
        .i_match_single(match_single), .i_match_discard(match_discard), .o_dd_valid(dd_valid),
        .o_dd(dd), .o_lookup_valid(lookup_valid), .o_lookup_vec(lookup_vec),
        .o_lookup_exempt(lookup_exempt), .o_src_vlan_vec(src_vlan_vec));

    ////////////////////////////////////////////////////////////////////////////////
    // Compares and verdict
    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp({28'h0, got}, {28'h0, exp});
    endtask
    task automatic chk_code(input logic [22:0] got, input logic [22:0] exp);
        cmp({13'h0, got}, {13'h0, exp});
    endtask
    task automatic chk_bus(input logic [35:0] got, input logic [35:0] exp);
        cmp(got, exp);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Management port accesses
    task automatic host_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge clk);
        host_wr = 1'b0;
    endtask
    task automatic host_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        host_addr = a;
        host_rd = 1'b1;
        @(negedge clk);
        host_rd = 1'b0;
        chk_reg(host_rdata, exp);
    endtask
    task automatic set_fwd(input flfe_vec_t v);
        host_write(ADDR_FWD_BLOCK_LO, v[7:0]);
        host_write(ADDR_FWD_BLOCK_HI, v[15:8]);
        fwd = v;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Frame runs
    function automatic logic [22:0] exp_norm(input flfe_vec_t v, input flfe_vec_t vlan, input flfe_port_t s);
        flfe_vec_t r;
        flfe_port_t p;
        r = v & vlan & ~(16'h0001 << s) & ~fwd;
        p = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (r[i]) begin
                p = 4'(i);
            end
        end
        if (r == 16'h0000) begin
            return {1'b1, 1'b0, 4'h0, 16'h0000, 1'b1};
        end
        return {1'b0, $onehot(r), p, r, 1'b1};
    endfunction

    task automatic frame(input flfe_port_t s, input int dly, input flfe_vec_t v, input flfe_vec_t vlan,
                         input logic ex);
        int n;
        logic d;
        i_flfe_ctl_model.cfg_vec = v;
        i_flfe_ctl_model.cfg_vlan = vlan;
        i_flfe_ctl_model.cfg_exempt = ex;
        i_flfe_ctl_model.delay = dly;
        i_flfe_ctl_model.send_frame(1'b0, s, SOF_FLAGS, {s, 28'h1234567});
        chk_bus({lookup_req, 3'h0, lookup_da}, {1'b1, 3'h0, s, 28'h1234567});
        chk_bus({32'h0, src_port}, {32'h0, s});
        n = 0;
        while (match_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk_bus(36'(n >= 1 && n <= DEADLINE_CYC), 36'h1);
        d = match_discard;
        code = {d, match_single, d ? 4'h0 : match_port, d ? 16'h0000 : match_vec, stat_count_en};
    endtask

    task automatic no_frame(input logic lst, input logic [1:0] flags);
        logic seen;
        seen = 1'b0;
        i_flfe_ctl_model.send_frame(lst, 4'h1, flags, 32'h0badcafe);
        repeat (6) begin
            seen = seen | (lookup_req !== 1'b0);
            @(negedge clk);
        end
        chk_bus({35'h0, seen}, 36'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        foreach (ra[i]) host_read(ra[i], rv[i]);
        host_write(8'h10, 8'h5a);
        host_write(ADDR_RX_BLOCK_LO, 8'ha5);
        host_write(ADDR_RX_BLOCK_HI, 8'h3c);
        host_read(ADDR_RX_BLOCK_LO, 8'ha5);
        host_read(ADDR_RX_BLOCK_HI, 8'h3c);
        host_read(8'h10, RDATA_NONE);
        host_write(ADDR_RX_BLOCK_HI, 8'h00);
        host_write(ADDR_RX_BLOCK_LO, 8'h00);
        frame(4'h3, 1, 16'h00ff, 16'h00f0, 1'b0);
        chk_code(code, exp_norm(16'h00ff, 16'h00f0, 4'h3));
        set_fwd(16'h0020);
        frame(4'h3, 4, 16'h0038, 16'hffff, 1'b0);
        chk_code(code, exp_norm(16'h0038, 16'hffff, 4'h3));
        frame(4'h2, 2, 16'h0024, 16'hffff, 1'b0);
        chk_code(code, exp_norm(16'h0024, 16'hffff, 4'h2));
        no_frame(1'b1, SOF_FLAGS);
        foreach (bad_flags[i]) no_frame(1'b0, bad_flags[i]);
        host_write(ADDR_RX_BLOCK_LO, 8'h08);
        frame(4'h3, 1, 16'h00c0, 16'hffff, 1'b0);
        chk_code(code, {1'b1, 1'b0, 4'h0, 16'h0000, 1'b0});
        frame(4'h3, 1, 16'h00c0, 16'hffff, 1'b1);
        chk_code(code, exp_norm(16'h00c0, 16'hffff, 4'h3));
        host_write(ADDR_RX_BLOCK_LO, 8'h00);
        host_write(ADDR_CPU_STEER, 8'h35);
        frame(4'h6, 1, 16'h0003, 16'hffff, 1'b0);
        chk_code(code, exp_norm(16'h0003, 16'hffff, 4'h6));
        host_read(ADDR_CPU_STEER, 8'h35);
        frame(4'h3, 1, 16'h0003, 16'hffff, 1'b0);
        chk_code(code, {1'b0, 1'b1, 4'h5, 16'h0020, 1'b1});
        host_read(ADDR_CPU_STEER, {4'h3, STEER_OFF});
        frame(4'h3, 1, 16'h0003, 16'hffff, 1'b0);
        chk_code(code, exp_norm(16'h0003, 16'hffff, 4'h3));
        host_write(ADDR_CPU_STEER, 8'hf2);
        frame(4'hf, 1, 16'h0003, 16'hffff, 1'b0);
        chk_code(code, exp_norm(16'h0003, 16'hffff, 4'hf));
        host_read(ADDR_CPU_STEER, 8'hf2);
        frame(4'h1, 12, 16'h0003, 16'hffff, 1'b0);
        chk_code(code, {1'b1, 1'b0, 4'h0, 16'h0000, 1'b0});
        repeat (4) @(negedge clk);
        chk_reg(8'(i_flfe_ctl_model.queued), 8'h02);
        chk_reg(8'(i_flfe_ctl_model.lists), 8'h05);
        tally_and_finish();
    end
endmodule

`default_nettype wire
